/* verilog/ata_xfer_mode_and_multiple_setup.sv */
`timescale 1ns/1ps
`default_nettype none
module ata_xfer_mode_and_multiple_setup #(
	parameter logic DEVICE_NUMBER = 1'b0,
	parameter int EXEC_CYCLES = ata_setup_pkg::EXEC_CYCLES
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// host task-file pins
	input wire logic i_cs_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_data,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_soft_reset,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic o_intrq,
	// state toward the rest of the drive
	output logic o_busy,
	output logic o_mult_enable,
	output logic [7:0] o_mult_count,
	output logic [4:0] o_xfer_type,
	output logic [2:0] o_xfer_mode,
	output logic o_pio4_capable,
	output logic o_mdma2_capable,
	output logic [15:0] o_id_word47,
	output logic [15:0] o_id_word59
);
	if (EXEC_CYCLES < 1 || EXEC_CYCLES > 255) begin
		$error("EXEC_CYCLES out of range");
	end

	localparam int SW = 15;
	localparam logic [7:0] EXEC_LOAD = 8'(EXEC_CYCLES - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_DONE = 2'b11
	} fsm_t;

	function automatic logic feature_known(input logic [7:0] f);
		case (f)
			ata_setup_pkg::FEAT_WCACHE_ON, ata_setup_pkg::FEAT_RCACHE_OFF,
			ata_setup_pkg::FEAT_KEEP_SETTINGS, ata_setup_pkg::FEAT_WCACHE_OFF,
			ata_setup_pkg::FEAT_RCACHE_ON, ata_setup_pkg::FEAT_ECC4,
			ata_setup_pkg::FEAT_REVERT_SETTINGS: feature_known = 1'b1;
			default: feature_known = 1'b0;
		endcase
	endfunction

	// pin synchroniser; stage one feeds stage two only
	logic [SW-1:0] sync1_reg, sync2_reg;
	logic rd_prev_reg, wr_prev_reg;
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_reg <= 15'h7000;
			sync2_reg <= 15'h7000;
			rd_prev_reg <= 1'b1;
			wr_prev_reg <= 1'b1;
		end else begin
			sync1_reg <= {i_cs_n, i_rd_n, i_wr_n, i_soft_reset, i_addr, i_data};
			sync2_reg <= sync1_reg;
			rd_prev_reg <= sync2_reg[13];
			wr_prev_reg <= sync2_reg[12];
		end
	end

	logic cs_s, rd_s, wr_s, srst_s;
	logic [2:0] addr_s;
	logic [7:0] data_s;
	logic rd_fall, wr_fall;
	// addr and data pass the same two stages as the strobes, so they line up;
	// the host must hold them stable for at least three clocks around the strobe edge
	assign {cs_s, rd_s, wr_s, srst_s, addr_s, data_s} = sync2_reg;
	assign rd_fall = rd_prev_reg & ~rd_s & ~cs_s;
	assign wr_fall = wr_prev_reg & ~wr_s & ~cs_s;

	logic xfer_valid, cnt_supported, cnt_zero;
	logic [4:0] xfer_type_dec;
	logic [2:0] xfer_mode_dec;

	// task file and command state
	fsm_t state_reg, state_next;
	logic [7:0] feature_reg, feature_next;
	logic [7:0] sector_count_reg, sector_count_next;
	logic [7:0] sector_number_reg, sector_number_next;
	logic [7:0] cylinder_low_reg, cylinder_low_next;
	logic [7:0] cylinder_high_reg, cylinder_high_next;
	logic [7:0] drive_head_select_reg, drive_head_select_next;
	logic [7:0] command_reg, command_next;
	logic [7:0] exec_cnt_reg, exec_cnt_next;
	logic busy_flag_reg, busy_flag_next;
	logic abort_reg, abort_next;
	logic intrq_reg, intrq_next;
	logic mult_en_reg, mult_en_next;
	logic [7:0] mult_cnt_reg, mult_cnt_next;
	logic [4:0] xtype_reg, xtype_next;
	logic [2:0] xmode_reg, xmode_next;
	logic [7:0] dout_reg, dout_next;
	logic oe_reg, oe_next;
	logic [15:0] w59_reg, w59_next;
	logic [7:0] status_reg, error_reg;
	logic selected;
	// fixed capabilities need no selection command to be usable
	logic caps_reg;
	logic [15:0] w47_reg;

	xfer_mode_decode u_xfer_decode (
		.i_code(sector_count_reg),
		.o_valid(xfer_valid),
		.o_type(xfer_type_dec),
		.o_mode(xfer_mode_dec)
	);

	block_count_check u_count_check (
		.i_count(sector_count_reg),
		.o_supported(cnt_supported),
		.o_zero(cnt_zero)
	);

	always_comb begin
		status_reg = 8'h00;
		status_reg[ata_setup_pkg::ST_BUSY_BIT] = busy_flag_reg;
		status_reg[ata_setup_pkg::ST_READY_BIT] = ~busy_flag_reg;
		status_reg[ata_setup_pkg::ST_ERR_BIT] = abort_reg;
		error_reg = 8'h00;
		error_reg[ata_setup_pkg::ER_ABORT_BIT] = abort_reg;
		selected = (drive_head_select_reg[ata_setup_pkg::DH_DEV_BIT] == DEVICE_NUMBER);
	end

	always_comb begin
		state_next = state_reg;
		feature_next = feature_reg;
		sector_count_next = sector_count_reg;
		sector_number_next = sector_number_reg;
		cylinder_low_next = cylinder_low_reg;
		cylinder_high_next = cylinder_high_reg;
		drive_head_select_next = drive_head_select_reg;
		command_next = command_reg;
		exec_cnt_next = exec_cnt_reg;
		busy_flag_next = busy_flag_reg;
		abort_next = abort_reg;
		intrq_next = intrq_reg;
		mult_en_next = mult_en_reg;
		mult_cnt_next = mult_cnt_reg;
		xtype_next = xtype_reg;
		xmode_next = xmode_reg;

		// reading status acknowledges the interrupt
		if (rd_fall && addr_s == ata_setup_pkg::OFF_STATUS_COMMAND[2:0]) begin
			intrq_next = 1'b0;
		end

		// task-file writes are ignored while busy
		if (wr_fall && !busy_flag_reg) begin
			case (addr_s)
				ata_setup_pkg::OFF_ERROR_FEATURE[2:0]: feature_next = data_s;
				ata_setup_pkg::OFF_SECTOR_COUNT[2:0]: sector_count_next = data_s;
				ata_setup_pkg::OFF_SECTOR_NUMBER[2:0]: sector_number_next = data_s;
				ata_setup_pkg::OFF_CYLINDER_LOW[2:0]: cylinder_low_next = data_s;
				ata_setup_pkg::OFF_CYLINDER_HIGH[2:0]: cylinder_high_next = data_s;
				ata_setup_pkg::OFF_DRIVE_HEAD[2:0]: drive_head_select_next = data_s;
				default: begin
					if (selected) begin
						command_next = data_s;
						busy_flag_next = 1'b1;
						abort_next = 1'b0;
						intrq_next = 1'b0;
						exec_cnt_next = EXEC_LOAD;
						state_next = ST_EXEC;
					end
				end
			endcase
		end

		case (state_reg)
			ST_IDLE: begin
			end
			ST_EXEC: begin
				if (exec_cnt_reg == 8'h00) begin
					state_next = ST_DONE;
				end else begin
					exec_cnt_next = exec_cnt_reg - 8'h01;
				end
			end
			ST_DONE: begin
				case (command_reg)
					ata_setup_pkg::CMD_SET_FEATURES: begin
						if (feature_reg == ata_setup_pkg::FEAT_XFER_MODE) begin
							if (xfer_valid) begin
								xtype_next = xfer_type_dec;
								xmode_next = xfer_mode_dec;
							end else begin
								abort_next = 1'b1;
							end
						end else if (!feature_known(feature_reg)) begin
							abort_next = 1'b1;
						end
					end
					ata_setup_pkg::CMD_SET_MULTIPLE: begin
						if (cnt_zero) begin
							mult_en_next = 1'b0;
						end else if (cnt_supported) begin
							mult_en_next = 1'b1;
							mult_cnt_next = sector_count_reg;
						end else begin
							mult_en_next = 1'b0;
							abort_next = 1'b1;
						end
					end
					default: abort_next = 1'b1;
				endcase
				busy_flag_next = 1'b0;
				intrq_next = 1'b1;
				state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase

		// software reset ends any command but keeps the multiple settings
		if (srst_s) begin
			state_next = ST_IDLE;
			busy_flag_next = 1'b0;
			abort_next = 1'b0;
			intrq_next = 1'b0;
			mult_en_next = mult_en_reg;
			mult_cnt_next = mult_cnt_reg;
		end
	end

	// read path and identify words
	always_comb begin
		oe_next = ~rd_s & ~cs_s;
		case (addr_s)
			ata_setup_pkg::OFF_ERROR_FEATURE[2:0]: dout_next = error_reg;
			ata_setup_pkg::OFF_SECTOR_COUNT[2:0]: dout_next = sector_count_reg;
			ata_setup_pkg::OFF_SECTOR_NUMBER[2:0]: dout_next = sector_number_reg;
			ata_setup_pkg::OFF_CYLINDER_LOW[2:0]: dout_next = cylinder_low_reg;
			ata_setup_pkg::OFF_CYLINDER_HIGH[2:0]: dout_next = cylinder_high_reg;
			ata_setup_pkg::OFF_DRIVE_HEAD[2:0]: dout_next = drive_head_select_reg;
			ata_setup_pkg::OFF_STATUS_COMMAND[2:0]: dout_next = status_reg;
			default: dout_next = 8'h00;
		endcase
		if (mult_en_next) begin
			w59_next = {ata_setup_pkg::ID_WORD59_ON_HI, mult_cnt_next};
		end else begin
			w59_next = ata_setup_pkg::ID_WORD59_OFF;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ST_IDLE;
			feature_reg <= ata_setup_pkg::RST_TASKFILE;
			sector_count_reg <= ata_setup_pkg::RST_TASKFILE;
			sector_number_reg <= ata_setup_pkg::RST_TASKFILE;
			cylinder_low_reg <= ata_setup_pkg::RST_TASKFILE;
			cylinder_high_reg <= ata_setup_pkg::RST_TASKFILE;
			drive_head_select_reg <= ata_setup_pkg::RST_TASKFILE;
			command_reg <= ata_setup_pkg::RST_TASKFILE;
			exec_cnt_reg <= 8'h00;
			busy_flag_reg <= 1'b0;
			abort_reg <= 1'b0;
			intrq_reg <= 1'b0;
			mult_en_reg <= 1'b0;
			mult_cnt_reg <= ata_setup_pkg::RST_BLOCK_COUNT;
			xtype_reg <= ata_setup_pkg::XT_PIO_DEFAULT;
			xmode_reg <= ata_setup_pkg::XM_DEFAULT;
			dout_reg <= 8'h00;
			oe_reg <= 1'b0;
			w59_reg <= ata_setup_pkg::ID_WORD59_OFF;
			caps_reg <= 1'b1;
			w47_reg <= ata_setup_pkg::ID_WORD47;
		end else begin
			state_reg <= state_next;
			feature_reg <= feature_next;
			sector_count_reg <= sector_count_next;
			sector_number_reg <= sector_number_next;
			cylinder_low_reg <= cylinder_low_next;
			cylinder_high_reg <= cylinder_high_next;
			drive_head_select_reg <= drive_head_select_next;
			command_reg <= command_next;
			exec_cnt_reg <= exec_cnt_next;
			busy_flag_reg <= busy_flag_next;
			abort_reg <= abort_next;
			intrq_reg <= intrq_next;
			mult_en_reg <= mult_en_next;
			mult_cnt_reg <= mult_cnt_next;
			xtype_reg <= xtype_next;
			xmode_reg <= xmode_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
			w59_reg <= w59_next;
			caps_reg <= 1'b1;
			w47_reg <= ata_setup_pkg::ID_WORD47;
		end
	end

	assign o_data = dout_reg;
	assign o_data_oe = oe_reg;
	assign o_intrq = intrq_reg;
	assign o_busy = busy_flag_reg;
	assign o_mult_enable = mult_en_reg;
	assign o_mult_count = mult_cnt_reg;
	assign o_xfer_type = xtype_reg;
	assign o_xfer_mode = xmode_reg;
	assign o_pio4_capable = caps_reg;
	assign o_mdma2_capable = caps_reg;
	assign o_id_word47 = w47_reg;
	assign o_id_word59 = w59_reg;
endmodule
`default_nettype wire

/* verilog/ata_setup_pkg.sv */
`default_nettype none
package ata_setup_pkg;
	// task-file offsets; the low three bits select the register
	localparam logic [9:0] OFF_ERROR_FEATURE = 10'h1f1;
	localparam logic [9:0] OFF_SECTOR_COUNT = 10'h1f2;
	localparam logic [9:0] OFF_SECTOR_NUMBER = 10'h1f3;
	localparam logic [9:0] OFF_CYLINDER_LOW = 10'h1f4;
	localparam logic [9:0] OFF_CYLINDER_HIGH = 10'h1f5;
	localparam logic [9:0] OFF_DRIVE_HEAD = 10'h1f6;
	localparam logic [9:0] OFF_STATUS_COMMAND = 10'h1f7;

	// command codes
	localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
	localparam logic [7:0] CMD_SET_MULTIPLE = 8'hc6;

	// feature codes
	localparam logic [7:0] FEAT_XFER_MODE = 8'h03;
	localparam logic [7:0] FEAT_WCACHE_ON = 8'h02;
	localparam logic [7:0] FEAT_RCACHE_OFF = 8'h55;
	localparam logic [7:0] FEAT_KEEP_SETTINGS = 8'h66;
	localparam logic [7:0] FEAT_WCACHE_OFF = 8'h82;
	localparam logic [7:0] FEAT_RCACHE_ON = 8'haa;
	localparam logic [7:0] FEAT_ECC4 = 8'hbb;
	localparam logic [7:0] FEAT_REVERT_SETTINGS = 8'hcc;

	// transfer-mode code layout: type in [7:3], mode in [2:0]
	localparam int XFER_TYPE_LSB = 3;
	localparam int XFER_TYPE_W = 5;
	localparam int XFER_MODE_W = 3;
	localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
	localparam logic [4:0] XT_PIO_FLOW = 5'h01;
	localparam logic [4:0] XT_SW_DMA = 5'h02;
	localparam logic [4:0] XT_MW_DMA = 5'h04;
	localparam logic [4:0] XT_ULTRA_DMA = 5'h08;
	localparam logic [2:0] XM_PIO_MAX = 3'h4;
	localparam logic [2:0] XM_DMA_MAX = 3'h2;
	localparam logic [2:0] XM_DEFAULT = 3'h0;

	// status and error bits
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_READY_BIT = 6;
	localparam int ST_ERR_BIT = 0;
	localparam int ER_ABORT_BIT = 2;
	localparam int DH_DEV_BIT = 4;

	// identify words
	localparam logic [15:0] ID_WORD47 = 16'h0020;
	localparam logic [15:0] ID_WORD59_OFF = 16'h0000;
	localparam logic [7:0] ID_WORD59_ON_HI = 8'h01;

	// reset values
	localparam logic [7:0] RST_TASKFILE = 8'h00;
	localparam logic [7:0] RST_BLOCK_COUNT = 8'h00;

	// command execution time with busy raised
	localparam int EXEC_TIME_NS = 50;
	localparam int CLK_PERIOD_NS = 25;
	localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

/* verilog/xfer_mode_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module xfer_mode_decode (
	// code from the sector count register
	input wire logic [7:0] i_code,
	// decoded result
	output logic o_valid,
	output logic [4:0] o_type,
	output logic [2:0] o_mode
);
	always_comb begin
		o_type = i_code[7:ata_setup_pkg::XFER_TYPE_LSB];
		o_mode = i_code[ata_setup_pkg::XFER_TYPE_LSB-1:0];
		case (o_type)
			ata_setup_pkg::XT_PIO_DEFAULT: o_valid = (o_mode == ata_setup_pkg::XM_DEFAULT);
			ata_setup_pkg::XT_PIO_FLOW: o_valid = (o_mode <= ata_setup_pkg::XM_PIO_MAX);
			ata_setup_pkg::XT_SW_DMA: o_valid = (o_mode <= ata_setup_pkg::XM_DMA_MAX);
			ata_setup_pkg::XT_MW_DMA: o_valid = (o_mode <= ata_setup_pkg::XM_DMA_MAX);
			ata_setup_pkg::XT_ULTRA_DMA: o_valid = (o_mode <= ata_setup_pkg::XM_DMA_MAX);
			default: o_valid = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

/* verilog/block_count_check.sv */
`timescale 1ns/1ps
`default_nettype none
module block_count_check (
	// requested sectors per block
	input wire logic [7:0] i_count,
	// verdict
	output logic o_supported,
	output logic o_zero
);
	always_comb begin
		o_zero = (i_count == 8'h00);
		case (i_count)
			8'h02, 8'h04, 8'h08, 8'h10, 8'h20: o_supported = 1'b1;
			default: o_supported = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

/* verif/xfer_setup_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module xfer_setup_monitor #(
	parameter int EXEC_CYCLES = 2
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// host strobes
	input wire logic i_cs_n,
	input wire logic [2:0] i_addr,
	input wire logic i_wr_n,
	input wire logic i_rd_n,
	// drive outputs
	input wire logic o_data_oe,
	input wire logic o_intrq,
	input wire logic o_busy,
	input wire logic o_mult_enable,
	input wire logic [7:0] o_mult_count,
	input wire logic [4:0] o_xfer_type,
	input wire logic [2:0] o_xfer_mode,
	input wire logic o_pio4_capable,
	input wire logic o_mdma2_capable,
	input wire logic [15:0] o_id_word47,
	input wire logic [15:0] o_id_word59
);
	logic [7:0] busy_len_reg;
	logic [7:0] busy_len_next;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	always_comb begin
		busy_len_next = o_busy ? busy_len_reg + 8'h01 : 8'h00;
	end
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			busy_len_reg <= 8'h00;
		end else begin
			busy_len_reg <= busy_len_next;
		end
	end

	// the repetition assumes the default of two counting clocks plus the done clock
	sequence s_busy_hold;
		o_busy [*3];
	endsequence
	sequence s_finish;
		!o_busy && o_intrq;
	endsequence

	a_busy_on_command: assert property ($rose(o_busy) |-> $past(!i_wr_n && !i_cs_n && i_addr == 3'h7))
		else $error("busy rose without a command write");
	a_exec_sequence: assert property ($rose(o_busy) |-> s_busy_hold ##1 s_finish)
		else $error("command did not end with busy low and interrupt high");
	a_busy_span: assert property ($fell(o_busy) |-> busy_len_reg == EXEC_CYCLES + 1)
		else $error("busy length wrong");
	a_mult_at_done: assert property (($changed(o_mult_enable) || $changed(o_mult_count)) |-> $fell(o_busy))
		else $error("multiple state changed outside command end");
	a_count_supported: assert property (o_mult_enable |-> o_mult_count inside {8'h02, 8'h04, 8'h08, 8'h10, 8'h20})
		else $error("enabled with unsupported block count");
	a_word59_map: assert property (o_id_word59 == (o_mult_enable ? {8'h01, o_mult_count} : 16'h0000))
		else $error("word 59 does not follow multiple state");
	a_word47_fixed: assert property (o_id_word47 == 16'h0020)
		else $error("word 47 not fixed");
	a_capable_always: assert property (o_pio4_capable && o_mdma2_capable)
		else $error("default capabilities lost");
	a_xfer_legal: assert property ((o_xfer_type == 5'h00 && o_xfer_mode == 3'h0) || (o_xfer_type == 5'h01 && o_xfer_mode <= 3'h4) || (o_xfer_type inside {5'h02, 5'h04, 5'h08} && o_xfer_mode <= 3'h2))
		else $error("illegal transfer mode held");
	// two synchroniser stages plus the output register give three clocks of latency
	a_oe_follows_strobe: assert property (o_data_oe == $past(!i_rd_n && !i_cs_n, 3))
		else $error("read drive enable does not follow the read strobe");
endmodule

bind ata_xfer_mode_and_multiple_setup xfer_setup_monitor #(.EXEC_CYCLES(EXEC_CYCLES)) monitor_inst (
	.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_addr(i_addr), .i_wr_n(i_wr_n),
	.i_rd_n(i_rd_n), .o_data_oe(o_data_oe),
	.o_intrq(o_intrq), .o_busy(o_busy), .o_mult_enable(o_mult_enable), .o_mult_count(o_mult_count),
	.o_xfer_type(o_xfer_type), .o_xfer_mode(o_xfer_mode), .o_pio4_capable(o_pio4_capable),
	.o_mdma2_capable(o_mdma2_capable), .o_id_word47(o_id_word47), .o_id_word59(o_id_word59)
);
`default_nettype wire

/* verif/ata_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ata_host_model (
	// clock
	input wire logic i_core_clk,
	// task-file pins toward the drive
	output logic o_cs_n,
	output logic [2:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_rd_n,
	output logic o_wr_n,
	// read data from the drive
	input wire logic [7:0] i_rdata
);
	// slow stretches every strobe, as an unhurried host would
	logic slow;

	initial begin
		slow = 1'b0;
		o_cs_n = 1'b1;
		o_addr = 3'h0;
		o_wdata = 8'h5a;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
	end

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_cs_n <= 1'b0;
		o_addr <= a;
		o_wdata <= d;
		o_wr_n <= 1'b0;
		repeat (slow ? 8 : 4) @(posedge i_core_clk);
		o_wr_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		o_cs_n <= 1'b1;
		// a released bus must not keep showing the last value
		o_wdata <= ~d;
	endtask

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		o_cs_n <= 1'b0;
		o_addr <= a;
		o_rd_n <= 1'b0;
		repeat (slow ? 8 : 5) @(posedge i_core_clk);
		d = i_rdata;
		o_rd_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		o_cs_n <= 1'b1;
	endtask

	// parameters first, command byte last
	task automatic issue(input logic [7:0] feat, input logic [7:0] count, input logic [7:0] dh, input logic [7:0] cmd);
		wr_reg(3'h1, feat);
		wr_reg(3'h2, count);
		wr_reg(3'h6, dh);
		wr_reg(3'h7, cmd);
	endtask
endmodule
`default_nettype wire

/* verif/ata_xfer_mode_and_multiple_setup_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ata_xfer_mode_and_multiple_setup_bench;
	localparam logic [119:0] XFER_OK = {8'h00, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h10, 8'h11, 8'h12,
		8'h20, 8'h21, 8'h22, 8'h40, 8'h41, 8'h42};
	localparam logic [63:0] XFER_BAD = {8'h01, 8'h07, 8'h0d, 8'h13, 8'h23, 8'h43, 8'h80, 8'hff};
	localparam logic [39:0] COUNT_OK = {8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
	localparam logic [39:0] COUNT_BAD = {8'h01, 8'h03, 8'h21, 8'h40, 8'hff};
	logic core_clk;
	logic rstn;
	logic soft_reset;
	logic cs_n;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic rd_n;
	logic wr_n;
	logic [7:0] rdata;
	logic intrq;
	logic busy;
	logic mult_enable;
	logic [7:0] mult_count;
	logic [4:0] xfer_type;
	logic [2:0] xfer_mode;
	logic pio4;
	logic mdma2;
	logic [15:0] word47;
	logic [15:0] word59;
	logic [7:0] st;
	logic [7:0] er;
	int err_count;
	int total_checks;

	always #12.5 core_clk = ~core_clk;

	ata_xfer_mode_and_multiple_setup #(.DEVICE_NUMBER(1'b0), .EXEC_CYCLES(2)) ata_xfer_mode_and_multiple_setup_inst (
		.i_core_clk(core_clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_addr(addr), .i_data(wdata), .i_rd_n(rd_n),
		.i_wr_n(wr_n), .i_soft_reset(soft_reset), .o_data(rdata), .o_data_oe(), .o_intrq(intrq), .o_busy(busy),
		.o_mult_enable(mult_enable), .o_mult_count(mult_count), .o_xfer_type(xfer_type), .o_xfer_mode(xfer_mode),
		.o_pio4_capable(pio4), .o_mdma2_capable(mdma2), .o_id_word47(word47), .o_id_word59(word59)
	);
	ata_host_model ata_host_model_inst (
		.i_core_clk(core_clk), .o_cs_n(cs_n), .o_addr(addr), .o_wdata(wdata), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.i_rdata(rdata)
	);

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wrap_up;
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// one command for this drive; error is read before status because the status read clears the interrupt
	task automatic run_cmd(input logic [7:0] feat, input logic [7:0] count, input logic [7:0] cmd);
		int n;
		n = 0;
		ata_host_model_inst.issue(feat, count, 8'ha0, cmd);
		while (intrq !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			n++;
		end
		chk("interrupt", 16'h0001, {15'h0000, intrq});
		ata_host_model_inst.rd_reg(3'h1, er);
		ata_host_model_inst.rd_reg(3'h7, st);
		chk("interrupt cleared", 16'h0000, {15'h0000, intrq});
	endtask

	task automatic t_reset;
		chk("mult enable", 16'h0000, {15'h0000, mult_enable});
		chk("word59", 16'h0000, word59);
		chk("word47", 16'h0020, word47);
		chk("capable", 16'h0003, {14'h0000, pio4, mdma2});
	endtask

	task automatic t_xfer;
		for (int i = 14; i >= 0; i--) begin
			run_cmd(8'h03, XFER_OK[i*8 +: 8], 8'hef);
			chk("xfer status", 16'h0040, {8'h00, st & 8'hc1});
			chk("xfer selected", {8'h00, XFER_OK[i*8 +: 8]}, {8'h00, xfer_type, xfer_mode});
		end
		for (int i = 0; i < 8; i++) begin
			run_cmd(8'h03, XFER_BAD[i*8 +: 8], 8'hef);
			chk("xfer abort status", 16'h0041, {8'h00, st & 8'hc1});
			chk("xfer abort error", 16'h0001, {15'h0000, er[2]});
			chk("xfer kept", 16'h0042, {8'h00, xfer_type, xfer_mode});
		end
	endtask

	task automatic t_mult;
		for (int i = 0; i < 5; i++) begin
			run_cmd(8'h00, COUNT_OK[i*8 +: 8], 8'hc6);
			chk("mult status", 16'h0040, {8'h00, st & 8'hc1});
			chk("mult enable", 16'h0001, {15'h0000, mult_enable});
			chk("word59", {8'h01, COUNT_OK[i*8 +: 8]}, word59);
		end
		for (int i = 0; i < 5; i++) begin
			run_cmd(8'h00, 8'h10, 8'hc6);
			run_cmd(8'h00, COUNT_BAD[i*8 +: 8], 8'hc6);
			chk("mult abort status", 16'h0041, {8'h00, st & 8'hc1});
			chk("mult abort error", 16'h0001, {15'h0000, er[2]});
			chk("mult disabled", 16'h0000, {15'h0000, mult_enable});
			chk("word59 off", 16'h0000, word59);
		end
		run_cmd(8'h00, 8'h10, 8'hc6);
		run_cmd(8'h00, 8'h00, 8'hc6);
		chk("mult zero", 16'h0000, {15'h0000, mult_enable});
		chk("word59 zero", 16'h0000, word59);
	endtask

	task automatic t_soft;
		run_cmd(8'h00, 8'h08, 8'hc6);
		run_cmd(8'h03, 8'h22, 8'hef);
		@(posedge core_clk);
		soft_reset <= 1'b1;
		repeat (6) @(posedge core_clk);
		soft_reset <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk("soft kept word59", 16'h0108, word59);
		chk("soft kept enable", 16'h0001, {15'h0000, mult_enable});
		chk("soft kept xfer", 16'h0022, {8'h00, xfer_type, xfer_mode});
		rstn <= 1'b0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("hard reset enable", 16'h0000, {15'h0000, mult_enable});
		chk("hard reset word59", 16'h0000, word59);
	endtask

	// a command for the other drive must raise neither busy nor the interrupt, and must leave word 59 unchanged
	task automatic t_dev;
		logic seen;
		seen = 1'b0;
		ata_host_model_inst.slow = 1'b1;
		ata_host_model_inst.issue(8'h00, 8'h20, 8'hb0, 8'hc6);
		repeat (30) begin
			@(posedge core_clk);
			seen = seen | busy | intrq;
		end
		chk("other drive ignored", 16'h0000, {15'h0000, seen});
		chk("other drive word59", 16'h0000, word59);
		run_cmd(8'h00, 8'h04, 8'hc6);
		chk("slow host word59", 16'h0104, word59);
	endtask

	// generous margin: the full sequence needs roughly three thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		wrap_up();
	end

	initial begin
		core_clk = 1'b0;
		rstn = 1'b0;
		soft_reset = 1'b0;
		err_count = 0;
		total_checks = 0;
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge core_clk);
		t_reset();
		t_xfer();
		t_mult();
		t_soft();
		t_dev();
		wrap_up();
	end
endmodule
`default_nettype wire
